// file: core/tmoc_params.svh
// constants of the two-channel timer output compare unit
//------------------------------------------------------------------------------
// How it works
// - counter reaching a channel's compare target sets its match flag
// - match with pin enabled drives match level; pin latch low in reset
// - compare values reset to 8000h: high byte 80h, low byte 00h
// - compare bytes read and write freely; hardware never alters them
// - compare of high:low against counter happens on every timer tick
// - match flag clears on status read seeing it, then low-byte access
// - writing compare high byte inhibits matches until low byte written
// - pin disabled: match level ignored, flag and interrupt still work
// - at cpu/2 flag and pin rise while counter equals compare value
// - at cpu/4 or cpu/8 they rise while counter equals compare plus one
// - force with pin enabled copies match level to pin, no flag or irq
// - interrupt when compare_irq_enable (bit 6) and a match flag set
// - interrupt when overflow_irq_enable (bit 5) and overflow flag set
// - one shared request, delivered only when global mask is clear
// - timer runs in wait; its interrupt wakes from wait, never from halt
// - halt stops counter; wake by interrupt resumes, reset restarts
// - clock_select bits 3:2: 00 cpu/4, 01 cpu/2, 10 cpu/8, 11 reserved
// - pin enables bits 7 and 6 gate only pins; compare stays active
// - overflow flag sets on FFFFh to 0000h; cleared via counter low only
// - status: match 1 bit 6, overflow bit 5, match 2 bit 3, rest zero
// - control a: force 2 b4, force 1 b3, level 2 b2, level 1 b0
// - writing counter low or alternate low reloads counter with FFFCh
//------------------------------------------------------------------------------
`ifndef TMOC_PARAMS_SVH
`define TMOC_PARAMS_SVH

// register addresses
`define TMOC_ADDR_CTRL_A      8'h20
`define TMOC_ADDR_CTRL_B      8'h21
`define TMOC_ADDR_STATUS      8'h22
`define TMOC_ADDR_CNT_HIGH    8'h23
`define TMOC_ADDR_CNT_LOW     8'h24
`define TMOC_ADDR_ALT_HIGH    8'h25
`define TMOC_ADDR_ALT_LOW     8'h26
`define TMOC_ADDR_CMP1_HIGH   8'h27
`define TMOC_ADDR_CMP1_LOW    8'h28
`define TMOC_ADDR_CMP2_HIGH   8'h29
`define TMOC_ADDR_CMP2_LOW    8'h2A

// control a fields
`define TMOC_CA_CMP_IRQ_EN    6
`define TMOC_CA_OVF_IRQ_EN    5
`define TMOC_CA_FORCE_2       4
`define TMOC_CA_FORCE_1       3
`define TMOC_CA_LEVEL_2       2
`define TMOC_CA_LEVEL_1       0
`define TMOC_CA_MASK          8'h7D

// control b fields
`define TMOC_CB_PIN_EN_1      7
`define TMOC_CB_PIN_EN_2      6
`define TMOC_CB_CLK_SEL_HI    3
`define TMOC_CB_CLK_SEL_LO    2
`define TMOC_CB_MASK          8'hCC

// status fields
`define TMOC_ST_MATCH_1       6
`define TMOC_ST_OVERFLOW      5
`define TMOC_ST_MATCH_2       3

// reset values
`define TMOC_RST_CTRL         8'h00
`define TMOC_RST_COUNTER      16'hFFFC
`define TMOC_RST_CMP_HIGH     8'h80
`define TMOC_RST_CMP_LOW      8'h00
`define TMOC_COUNTER_TOP      16'hFFFF

// prescale terminal counts (divide minus one)
`define TMOC_DIV2_LAST        3'h1
`define TMOC_DIV4_LAST        3'h3
`define TMOC_DIV8_LAST        3'h7

`endif

// file: core/tmoc_pkg.sv
// types of the two-channel timer output compare unit
`default_nettype none

package tmoc_pkg;

    typedef enum logic [1:0] {
        TMOC_CLK_DIV4 = 2'h0,
        TMOC_CLK_DIV2 = 2'h1,
        TMOC_CLK_DIV8 = 2'h2,
        TMOC_CLK_RSVD = 2'h3
    } tmoc_clk_sel_t;

endpackage : tmoc_pkg

`default_nettype wire

// file: core/tmoc_top.sv
// two-channel output compare unit with its free-running counter and registers
`timescale 1ns/1ps
`default_nettype none
`include "tmoc_params.svh"

module tmoc_top
    import tmoc_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    // register port
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [7:0]  o_reg_rdata,
    // processor state
    input  wire logic        i_irq_mask,
    input  wire logic        i_wait_mode,
    input  wire logic        i_halt_mode,
    // interrupt and wake
    output logic             o_timer_irq,
    output logic             o_wait_wake,
    // compare pins
    output logic             o_compare_out_1,
    output logic             o_compare_oe_1,
    output logic             o_compare_out_2,
    output logic             o_compare_oe_2
);

    //--------------------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------------------
    function automatic logic [2:0] tmoc_div_last(input tmoc_clk_sel_t sel);
        unique case (sel)
            TMOC_CLK_DIV2: tmoc_div_last = `TMOC_DIV2_LAST;
            TMOC_CLK_DIV8: tmoc_div_last = `TMOC_DIV8_LAST;
            TMOC_CLK_DIV4: tmoc_div_last = `TMOC_DIV4_LAST;
            TMOC_CLK_RSVD: tmoc_div_last = `TMOC_DIV4_LAST;
        endcase
    endfunction : tmoc_div_last

    // compare target: plus one except at cpu/2
    function automatic logic [15:0] tmoc_target(input logic [15:0] cmp, input logic div2);
        tmoc_target = div2 ? cmp : 16'(cmp + 16'h0001);
    endfunction : tmoc_target

    //--------------------------------------------------------------------------
    // register state
    //--------------------------------------------------------------------------
    logic [7:0]  ctrl_a_r;
    logic [7:0]  ctrl_b_r;
    logic [7:0]  cmp_high_r [2];
    logic [7:0]  cmp_low_r  [2];
    logic [1:0]  inhibit_r;
    logic [1:0]  match_flag_r;
    logic [1:0]  match_arm_r;
    logic        ovf_flag_r;
    logic        ovf_arm_r;
    logic [15:0] counter_r;
    logic [15:0] counter_nxt;
    logic [2:0]  presc_r;
    logic [1:0]  pin_r;

    logic        wr_cnt_low;
    logic        acc_cnt_low;
    logic [1:0]  wr_cmp_high;
    logic [1:0]  wr_cmp_low;
    logic [1:0]  acc_cmp_low;
    logic        rd_status;
    logic        tick;
    logic        div2;
    logic [1:0]  match_hit;
    logic [1:0]  pin_en;
    logic [1:0]  force_en;
    logic [1:0]  level;
    tmoc_clk_sel_t clk_sel;

    assign wr_cnt_low  = i_reg_wr && (i_reg_addr == `TMOC_ADDR_CNT_LOW ||
                                      i_reg_addr == `TMOC_ADDR_ALT_LOW);
    assign acc_cnt_low = (i_reg_wr || i_reg_rd) && i_reg_addr == `TMOC_ADDR_CNT_LOW;
    assign rd_status   = i_reg_rd && i_reg_addr == `TMOC_ADDR_STATUS;
    assign wr_cmp_high = {i_reg_wr && i_reg_addr == `TMOC_ADDR_CMP2_HIGH,
                          i_reg_wr && i_reg_addr == `TMOC_ADDR_CMP1_HIGH};
    assign wr_cmp_low  = {i_reg_wr && i_reg_addr == `TMOC_ADDR_CMP2_LOW,
                          i_reg_wr && i_reg_addr == `TMOC_ADDR_CMP1_LOW};
    assign acc_cmp_low = {(i_reg_wr || i_reg_rd) && i_reg_addr == `TMOC_ADDR_CMP2_LOW,
                          (i_reg_wr || i_reg_rd) && i_reg_addr == `TMOC_ADDR_CMP1_LOW};

    assign clk_sel  = tmoc_clk_sel_t'(ctrl_b_r[`TMOC_CB_CLK_SEL_HI:`TMOC_CB_CLK_SEL_LO]);
    assign div2     = (clk_sel == TMOC_CLK_DIV2);
    assign pin_en   = {ctrl_b_r[`TMOC_CB_PIN_EN_2], ctrl_b_r[`TMOC_CB_PIN_EN_1]};
    assign force_en = {ctrl_a_r[`TMOC_CA_FORCE_2], ctrl_a_r[`TMOC_CA_FORCE_1]};
    assign level    = {ctrl_a_r[`TMOC_CA_LEVEL_2], ctrl_a_r[`TMOC_CA_LEVEL_1]};

    //--------------------------------------------------------------------------
    // control registers
    //--------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ctrl_a_r <= `TMOC_RST_CTRL;
            ctrl_b_r <= `TMOC_RST_CTRL;
        end else if (i_reg_wr && i_reg_addr == `TMOC_ADDR_CTRL_A) begin
            ctrl_a_r <= i_reg_wdata & `TMOC_CA_MASK;
        end else if (i_reg_wr && i_reg_addr == `TMOC_ADDR_CTRL_B) begin
            ctrl_b_r <= i_reg_wdata & `TMOC_CB_MASK;
        end
    end

    //--------------------------------------------------------------------------
    // compare value registers, software only
    //--------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            for (int i = 0; i < 2; i++) begin
                cmp_high_r[i] <= `TMOC_RST_CMP_HIGH;
                cmp_low_r[i]  <= `TMOC_RST_CMP_LOW;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_cmp_high[i]) begin
                    cmp_high_r[i] <= i_reg_wdata;
                end
                if (wr_cmp_low[i]) begin
                    cmp_low_r[i] <= i_reg_wdata;
                end
            end
        end
    end

    // high byte write holds off compares until the pair is complete
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            inhibit_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_cmp_low[i]) begin
                    inhibit_r[i] <= 1'b0;
                end else if (wr_cmp_high[i]) begin
                    inhibit_r[i] <= 1'b1;
                end
            end
        end
    end

    //--------------------------------------------------------------------------
    // prescaler and free-running counter
    //--------------------------------------------------------------------------
    // halt freezes both, so counting resumes from the held value
    assign tick = !i_halt_mode && presc_r >= tmoc_div_last(clk_sel);

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || wr_cnt_low) begin
            presc_r <= 3'h0;
        end else if (!i_halt_mode) begin
            presc_r <= tick ? 3'h0 : 3'(presc_r + 3'h1);
        end
    end

    assign counter_nxt = 16'(counter_r + 16'h0001);

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || wr_cnt_low) begin
            counter_r <= `TMOC_RST_COUNTER;
        end else if (tick) begin
            counter_r <= counter_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // match detection: flag rises with the counter step onto the target
    //--------------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            match_hit[i] = tick && !inhibit_r[i] && !wr_cnt_low &&
                           counter_nxt ==
                           tmoc_target({cmp_high_r[i], cmp_low_r[i]}, div2);
        end
    end

    //--------------------------------------------------------------------------
    // match flags: status read arms, low-byte access clears; set wins
    //--------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            match_flag_r <= 2'h0;
            match_arm_r  <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (match_hit[i]) begin
                    match_flag_r[i] <= 1'b1;
                end else if (match_arm_r[i] && acc_cmp_low[i]) begin
                    match_flag_r[i] <= 1'b0;
                end
                if (acc_cmp_low[i]) begin
                    match_arm_r[i] <= 1'b0;
                end else if (rd_status && match_flag_r[i]) begin
                    match_arm_r[i] <= 1'b1;
                end
            end
        end
    end

    //--------------------------------------------------------------------------
    // overflow flag
    //--------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ovf_flag_r <= 1'b0;
            ovf_arm_r  <= 1'b0;
        end else begin
            if (tick && !wr_cnt_low && counter_r == `TMOC_COUNTER_TOP) begin
                ovf_flag_r <= 1'b1;
            end else if (ovf_arm_r && acc_cnt_low) begin
                ovf_flag_r <= 1'b0;
            end
            if (acc_cnt_low) begin
                ovf_arm_r <= 1'b0;
            end else if (rd_status && ovf_flag_r) begin
                ovf_arm_r <= 1'b1;
            end
        end
    end

    //--------------------------------------------------------------------------
    // compare pins
    //--------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            pin_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (pin_en[i] && (force_en[i] || match_hit[i])) begin
                    pin_r[i] <= level[i];
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_compare_out_1 <= 1'b0;
            o_compare_out_2 <= 1'b0;
            o_compare_oe_1  <= 1'b0;
            o_compare_oe_2  <= 1'b0;
        end else begin
            o_compare_out_1 <= pin_r[0];
            o_compare_out_2 <= pin_r[1];
            o_compare_oe_1  <= pin_en[0];
            o_compare_oe_2  <= pin_en[1];
        end
    end

    //--------------------------------------------------------------------------
    // interrupt request and wake
    //--------------------------------------------------------------------------
    logic irq_src;
    assign irq_src = (ctrl_a_r[`TMOC_CA_CMP_IRQ_EN] && |match_flag_r) ||
                     (ctrl_a_r[`TMOC_CA_OVF_IRQ_EN] && ovf_flag_r);

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_timer_irq <= 1'b0;
            o_wait_wake <= 1'b0;
        end else begin
            o_timer_irq <= irq_src && !i_irq_mask;
            o_wait_wake <= irq_src && i_wait_mode && !i_halt_mode;
        end
    end

    //--------------------------------------------------------------------------
    // read port, data one cycle after the strobe
    //--------------------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (i_reg_addr)
            `TMOC_ADDR_CTRL_A:   rd_mux = ctrl_a_r;
            `TMOC_ADDR_CTRL_B:   rd_mux = ctrl_b_r;
            `TMOC_ADDR_STATUS: begin
                rd_mux[`TMOC_ST_MATCH_1]  = match_flag_r[0];
                rd_mux[`TMOC_ST_OVERFLOW] = ovf_flag_r;
                rd_mux[`TMOC_ST_MATCH_2]  = match_flag_r[1];
            end
            `TMOC_ADDR_CNT_HIGH,
            `TMOC_ADDR_ALT_HIGH: rd_mux = counter_r[15:8];
            `TMOC_ADDR_CNT_LOW,
            `TMOC_ADDR_ALT_LOW:  rd_mux = counter_r[7:0];
            `TMOC_ADDR_CMP1_HIGH: rd_mux = cmp_high_r[0];
            `TMOC_ADDR_CMP1_LOW:  rd_mux = cmp_low_r[0];
            `TMOC_ADDR_CMP2_HIGH: rd_mux = cmp_high_r[1];
            `TMOC_ADDR_CMP2_LOW:  rd_mux = cmp_low_r[1];
            default:              rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rd_mux;
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

endmodule : tmoc_top

`default_nettype wire

// file: tb/tmoc_properties.sv
// port-level assertions for the output compare unit
`timescale 1ns/1ps
`default_nettype none
`include "tmoc_params.svh"

module tmoc_props (
    // clock and reset
    input wire logic       i_clk_sys,
    input wire logic       i_sys_rst,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    // processor state
    input wire logic       i_irq_mask,
    input wire logic       i_wait_mode,
    input wire logic       i_halt_mode,
    // results
    input wire logic       o_timer_irq,
    input wire logic       o_wait_wake,
    input wire logic       o_compare_out_1,
    input wire logic       o_compare_oe_1,
    input wire logic       o_compare_out_2,
    input wire logic       o_compare_oe_2
);
    //--------------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);

    AST_RDATA_IDLE: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_STATUS_RSVD: assert property (i_reg_rd && i_reg_addr == `TMOC_ADDR_STATUS
        |=> (o_reg_rdata & 8'h97) == 8'h00) else $error("status reserved bit set");
    AST_CTRLA_RSVD: assert property (i_reg_rd && i_reg_addr == `TMOC_ADDR_CTRL_A
        |=> !o_reg_rdata[7] && !o_reg_rdata[1]) else $error("control a reserved bit set");
    AST_CTRLB_RSVD: assert property (i_reg_rd && i_reg_addr == `TMOC_ADDR_CTRL_B
        |=> (o_reg_rdata & 8'h33) == 8'h00) else $error("control b reserved bit set");
    AST_PIN_ENABLE: assert property (i_reg_wr && i_reg_addr == `TMOC_ADDR_CTRL_B |=>
        ##1 o_compare_oe_1 == $past(i_reg_wdata[7], 2) &&
        o_compare_oe_2 == $past(i_reg_wdata[6], 2))
        else $error("pin enable does not follow control b");
    AST_IRQ_MASKED: assert property (i_irq_mask |=> !o_timer_irq)
        else $error("interrupt while masked");
    AST_WAKE_HALT: assert property (i_halt_mode |=> !o_wait_wake)
        else $error("wake raised in halt");
    AST_WAKE_WAIT: assert property (!i_wait_mode |=> !o_wait_wake)
        else $error("wake raised outside wait");
    AST_WAKE_IRQ: assert property (i_wait_mode && !i_halt_mode && !i_irq_mask
        |=> o_wait_wake == o_timer_irq) else $error("wake differs from interrupt");
    AST_RST_QUIET: assert property (disable iff (1'b0) i_sys_rst
        |=> !o_compare_out_1 && !o_compare_out_2 && !o_timer_irq && !o_wait_wake)
        else $error("output high after reset edge");

    COV_IRQ: cover property ($rose(o_timer_irq));
    COV_PIN: cover property ($rose(o_compare_out_1));
    COV_WAKE: cover property ($rose(o_wait_wake));
endmodule : tmoc_props
`default_nettype wire

// file: tb/tmoc_bench.sv
// self-checking bench for the output compare unit
`timescale 1ns/1ps
`default_nettype none
`include "tmoc_params.svh"

module tmoc_bench
    import tmoc_pkg::*;
;
    logic       i_clk_sys, i_sys_rst, i_reg_wr, i_reg_rd, i_irq_mask, i_wait_mode, i_halt_mode;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, v;
    logic       o_timer_irq, o_wait_wake, o_compare_out_1, o_compare_oe_1;
    logic       o_compare_out_2, o_compare_oe_2;
    int         n_mismatch = 0, n_compared = 0, cycles = 0, t, e;
    tmoc_clk_sel_t sel [4] = '{TMOC_CLK_DIV2, TMOC_CLK_DIV4, TMOC_CLK_DIV8, TMOC_CLK_RSVD};
    int         div [4] = '{2, 4, 8, 4};
    int         ahead [4] = '{0, 1, 1, 1};
    logic [7:0] ra [8] = '{`TMOC_ADDR_STATUS, `TMOC_ADDR_CTRL_A, `TMOC_ADDR_CTRL_B,
        `TMOC_ADDR_CMP1_HIGH, `TMOC_ADDR_CMP1_LOW, `TMOC_ADDR_CMP2_HIGH, `TMOC_ADDR_CMP2_LOW, 8'h30};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00};

    tmoc_top DUT (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_irq_mask(i_irq_mask), .i_wait_mode(i_wait_mode),
        .i_halt_mode(i_halt_mode), .o_timer_irq(o_timer_irq), .o_wait_wake(o_wait_wake),
        .o_compare_out_1(o_compare_out_1), .o_compare_oe_1(o_compare_oe_1),
        .o_compare_out_2(o_compare_out_2), .o_compare_oe_2(o_compare_oe_2));

    //--------------------------------------------------------------------------
    // tasks
    //--------------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        #1 d = o_reg_rdata;
    endtask : rd

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] d;
        rd(a, d);
        chk(d, x);
    endtask : rd_chk

    // {irq, wake, oe1, oe2, out1, out2} once the output flops settle
    task automatic outs(input logic [7:0] x);
        repeat (4) @(posedge i_clk_sys);
        #1 chk({2'b00, o_timer_irq, o_wait_wake, o_compare_oe_1, o_compare_oe_2,
            o_compare_out_1, o_compare_out_2}, x);
    endtask : outs

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    //--------------------------------------------------------------------------
    // clock, timeout, sequence
    //--------------------------------------------------------------------------
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        {i_reg_addr, i_reg_wdata, i_reg_wr, i_reg_rd} = '0;
        {i_irq_mask, i_wait_mode, i_halt_mode} = '0;
        i_sys_rst = 1'b1;
        repeat (12) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        for (int k = 0; k < 8; k++) rd_chk(ra[k], rv[k]);
        outs(8'h00);
        wr(`TMOC_ADDR_CTRL_A, 8'hFF);
        rd_chk(`TMOC_ADDR_CTRL_A, 8'h7D);
        wr(`TMOC_ADDR_CTRL_B, 8'h33);
        rd_chk(`TMOC_ADDR_CTRL_B, 8'h00);
        wr(`TMOC_ADDR_STATUS, 8'hFF);
        rd_chk(`TMOC_ADDR_STATUS, 8'h20);
        for (int k = 0; k < 4; k++) begin
            wr(8'(`TMOC_ADDR_CMP1_HIGH + k), 8'(8'hA5 + k));
            rd_chk(8'(`TMOC_ADDR_CMP1_HIGH + k), 8'(8'hA5 + k));
        end
        $display("test registers done");
        // each clock select, last one with both pins released
        for (int m = 0; m < 4; m++) begin
            wr(`TMOC_ADDR_CTRL_A, m[0] ? 8'h40 : 8'h45);
            wr(`TMOC_ADDR_CTRL_B, {(m == 3) ? 4'h0 : 4'hC, sel[m], 2'b00});
            wr(`TMOC_ADDR_CMP1_HIGH, 8'h00);
            wr(`TMOC_ADDR_CMP2_HIGH, 8'h00);
            rd(`TMOC_ADDR_STATUS, v);
            wr(`TMOC_ADDR_CMP1_LOW, 8'h10);
            wr(`TMOC_ADDR_CMP2_LOW, 8'h10);
            wr(`TMOC_ADDR_CNT_LOW, 8'h00);
            t = 0;
            do begin
                @(posedge i_clk_sys);
                #1 t++;
            end while (o_timer_irq !== 1'b1 && t < 300);
            // one cycle of slack for prescaler phase; a whole count is 2 cycles or more
            e = (20 + ahead[m]) * div[m] + 1;
            chk({7'h00, t >= e - 1 && t <= e + 1}, 8'h01);
            rd_chk(`TMOC_ADDR_STATUS, 8'h68);
            outs({4'h2, m != 3, m != 3, m != 1, m != 1});
            rd(`TMOC_ADDR_ALT_LOW, v);
            rd_chk(`TMOC_ADDR_CMP1_LOW, 8'h10);
            wr(`TMOC_ADDR_CMP2_LOW, 8'h10);
            rd_chk(`TMOC_ADDR_STATUS, 8'h20);
            rd(`TMOC_ADDR_CNT_LOW, v);
            rd_chk(`TMOC_ADDR_STATUS, 8'h00);
            outs({4'h0, m != 3, m != 3, m != 1, m != 1});
            $display("test compare select %0d done", m);
        end
        wr(`TMOC_ADDR_CTRL_B, 8'hC4);
        wr(`TMOC_ADDR_CMP1_HIGH, 8'h00);
        wr(`TMOC_ADDR_CNT_LOW, 8'h00);
        repeat (60) @(posedge i_clk_sys);
        rd_chk(`TMOC_ADDR_STATUS, 8'h28);
        outs(8'h2E);
        @(posedge i_clk_sys);
        i_wait_mode <= 1'b1;
        outs(8'h3E);
        @(posedge i_clk_sys);
        i_irq_mask <= 1'b1;
        outs(8'h1E);
        @(posedge i_clk_sys);
        i_halt_mode <= 1'b1;
        outs(8'h0E);
        @(posedge i_clk_sys);
        {i_irq_mask, i_wait_mode, i_halt_mode} <= 3'b000;
        wr(`TMOC_ADDR_CTRL_A, 8'h20);
        outs(8'h2E);
        wr(`TMOC_ADDR_CTRL_A, 8'h00);
        outs(8'h0E);
        $display("test interrupt and wake done");
        // slow clock keeps the next overflow clear of the force checks
        wr(`TMOC_ADDR_CTRL_B, 8'hC8);
        wr(`TMOC_ADDR_CMP1_HIGH, 8'h80);
        wr(`TMOC_ADDR_CMP2_HIGH, 8'h80);
        rd(`TMOC_ADDR_STATUS, v);
        wr(`TMOC_ADDR_CMP1_LOW, 8'h00);
        wr(`TMOC_ADDR_CMP2_LOW, 8'h00);
        wr(`TMOC_ADDR_CNT_LOW, 8'h00);
        wr(`TMOC_ADDR_CTRL_A, 8'h18);
        outs(8'h0C);
        wr(`TMOC_ADDR_CTRL_A, 8'h1D);
        outs(8'h0F);
        rd(`TMOC_ADDR_STATUS, v);
        chk(v & 8'h48, 8'h00);
        $display("test force done");
        @(posedge i_clk_sys);
        i_halt_mode <= 1'b1;
        wr(`TMOC_ADDR_ALT_LOW, 8'h00);
        repeat (20) @(posedge i_clk_sys);
        rd_chk(`TMOC_ADDR_CNT_LOW, 8'hFC);
        rd_chk(`TMOC_ADDR_ALT_HIGH, 8'hFF);
        rd_chk(`TMOC_ADDR_CNT_HIGH, 8'hFF);
        @(posedge i_clk_sys);
        i_halt_mode <= 1'b0;
        repeat (20) @(posedge i_clk_sys);
        rd(`TMOC_ADDR_CNT_LOW, v);
        chk({7'h00, v != 8'hFC}, 8'h01);
        $display("test halt done");
        final_report();
    end
endmodule : tmoc_bench

bind tmoc_top tmoc_props u_props (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_irq_mask(i_irq_mask),
    .i_wait_mode(i_wait_mode), .i_halt_mode(i_halt_mode), .o_timer_irq(o_timer_irq),
    .o_wait_wake(o_wait_wake), .o_compare_out_1(o_compare_out_1),
    .o_compare_oe_1(o_compare_oe_1), .o_compare_out_2(o_compare_out_2),
    .o_compare_oe_2(o_compare_oe_2));
`default_nettype wire
